// ---- ufc_fault_cfg.sv ----
// Output undervoltage and overcurrent fault configuration with undervoltage response control
`timescale 1ns/1ps
module ufc_fault_cfg #(
    parameter logic [31:0] STEP_WAIT_CYC = 32'(ufc_pkg::RETRY_STEP_CYC),
    parameter logic [31:0] LONG_WAIT_CYC = 32'(ufc_pkg::RETRY_LONG_CYC)
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_page,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_error,
    input wire logic [15:0] vout_mv,
    input wire logic [15:0] iout_sum,
    input wire logic meas_valid,
    input wire logic output_ramping,
    input wire logic op_on,
    input wire logic other_fault_off,
    input wire logic fault_clear,
    input wire logic ctrl_pin,
    input wire logic bias_ok,
    output logic output_enable,
    output logic uv_fault_status,
    output logic oc_fault_status,
    output logic alert_output_n
);
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    logic ctrl_on;
    logic bias_on;
    logic enable_req;

    logic [15:0] uv_thr_reg;
    logic [15:0] uv_thr_next;
    logic [7:0] uv_act_reg;
    logic [7:0] uv_act_next;
    logic [15:0] oc_thr_reg;
    logic [15:0] oc_thr_next;

    logic sel_uv_thr;
    logic sel_uv_act;
    logic sel_oc_thr;
    logic code_hit;
    logic act_ok;
    logic wdata_ok;
    logic wr_ok;
    logic cmd_bad;
    logic [15:0] rd_mux;

    logic rsp_valid_reg;
    logic [15:0] rsp_rdata_reg;
    logic rsp_error_reg;

    logic [1:0] act_field;
    logic [2:0] retry_field;
    logic uv_arm;
    logic uv_trip;
    logic oc_trip;
    logic uv_disable;
    logic uv_flag_reg;
    logic uv_flag_next;
    logic oc_flag_reg;
    logic oc_flag_next;
    logic alert_reg;
    logic oe_reg;

    ufc_pkg::ufc_state_e state_reg;
    ufc_pkg::ufc_state_e state_next;
    logic tmr_start;
    logic tmr_abort;

    ufc_timer_if tif ();

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Control pin and bias good pin synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
        end else begin
            pin_meta_reg <= {bias_ok, ctrl_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign ctrl_on = pin_sync_reg[0];
    assign bias_on = pin_sync_reg[1];
    assign enable_req = ctrl_on & bias_on & op_on;

    // page ignored, command code alone selects
    assign sel_uv_thr = (cmd_code == ufc_pkg::CMD_UV_THR);
    assign sel_uv_act = (cmd_code == ufc_pkg::CMD_UV_ACT);
    assign sel_oc_thr = (cmd_code == ufc_pkg::CMD_OC_THR);
    assign code_hit = sel_uv_thr | sel_uv_act | sel_oc_thr;

    assign act_ok = (cmd_wdata[15:8] == ufc_pkg::BYTE_ZERO)
        & ((cmd_wdata[ufc_pkg::ACT_MSB:ufc_pkg::ACT_LSB] == ufc_pkg::ACT_CONTINUE)
        | (cmd_wdata[ufc_pkg::ACT_MSB:ufc_pkg::ACT_LSB] == ufc_pkg::ACT_DISABLE))
        & ((cmd_wdata[ufc_pkg::RETRY_MSB:ufc_pkg::RETRY_LSB] == ufc_pkg::RETRY_NONE)
        | (cmd_wdata[ufc_pkg::RETRY_MSB:ufc_pkg::RETRY_LSB] == ufc_pkg::RETRY_FOREVER));

    assign wdata_ok = sel_uv_thr ? (cmd_wdata <= ufc_pkg::UV_THR_MAX) :
                      sel_oc_thr ? (cmd_wdata <= ufc_pkg::OC_THR_MAX) :
                      sel_uv_act ? act_ok : 1'b0;
    assign wr_ok = cmd_valid & cmd_write & code_hit & wdata_ok;
    assign cmd_bad = cmd_valid & (~code_hit | (cmd_write & ~wdata_ok));

    // Read data selection
    assign rd_mux = sel_uv_thr ? uv_thr_reg :
                    sel_uv_act ? {ufc_pkg::BYTE_ZERO, uv_act_reg} :
                    sel_oc_thr ? oc_thr_reg : 16'h0000;

    // Next values of the three configuration registers
    assign uv_thr_next = (wr_ok & sel_uv_thr) ? cmd_wdata : uv_thr_reg;
    assign uv_act_next = (wr_ok & sel_uv_act) ? cmd_wdata[7:0] : uv_act_reg;
    assign oc_thr_next = (wr_ok & sel_oc_thr) ? cmd_wdata : oc_thr_reg;

    // configuration storage with documented reset values
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_thr_reg <= ufc_pkg::UV_THR_RST;
            uv_act_reg <= ufc_pkg::UV_ACT_RST;
            oc_thr_reg <= ufc_pkg::OC_THR_RST;
        end else begin
            uv_thr_reg <= uv_thr_next;
            uv_act_reg <= uv_act_next;
            oc_thr_reg <= oc_thr_next;
        end
    end

    // Answer one cycle after each command
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 16'h0000;
            rsp_error_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= cmd_valid;
            rsp_rdata_reg <= (cmd_valid & ~cmd_write) ? rd_mux : 16'h0000;
            rsp_error_reg <= cmd_bad;
        end
    end

    // Response fields and fault detection
    assign act_field = uv_act_reg[ufc_pkg::ACT_MSB:ufc_pkg::ACT_LSB];
    assign retry_field = uv_act_reg[ufc_pkg::RETRY_MSB:ufc_pkg::RETRY_LSB];
    // armed only while running and not ramping
    assign uv_arm = (state_reg == ufc_pkg::ST_RUN) & ~output_ramping;
    assign uv_trip = uv_arm & meas_valid & (vout_mv < uv_thr_reg);
    assign oc_trip = meas_valid & (iout_sum > oc_thr_reg);
    assign uv_disable = uv_trip & (act_field == ufc_pkg::ACT_DISABLE);

    // sticky flags, a new fault wins over a clear
    assign uv_flag_next = uv_trip | (uv_flag_reg & ~fault_clear);
    assign oc_flag_next = oc_trip | (oc_flag_reg & ~fault_clear);

    // Output control sequence
    always_comb begin
        state_next = state_reg;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        unique case (state_reg)
            ufc_pkg::ST_OFF: begin
                if (enable_req) begin
                    state_next = ufc_pkg::ST_RUN;
                end
            end
            ufc_pkg::ST_RUN: begin
                if (!enable_req) begin
                    state_next = ufc_pkg::ST_OFF;
                end else if (other_fault_off) begin
                    state_next = ufc_pkg::ST_LATCHED;
                end else if (uv_disable) begin
                    // endless retry after the selected wait
                    if (retry_field == ufc_pkg::RETRY_FOREVER) begin
                        state_next = ufc_pkg::ST_RETRY_WAIT;
                        tmr_start = 1'b1;
                    end else begin
                        state_next = ufc_pkg::ST_LATCHED;
                    end
                end
            end
            ufc_pkg::ST_RETRY_WAIT: begin
                // retries end on turn off or shutdown
                if (!enable_req) begin
                    state_next = ufc_pkg::ST_OFF;
                    tmr_abort = 1'b1;
                end else if (other_fault_off) begin
                    state_next = ufc_pkg::ST_LATCHED;
                    tmr_abort = 1'b1;
                end else if (tif.done) begin
                    state_next = ufc_pkg::ST_RUN;
                end
            end
            ufc_pkg::ST_LATCHED: begin
                if (!enable_req) begin
                    state_next = ufc_pkg::ST_OFF;
                end
            end
        endcase
    end

    // Timer hookup
    assign tif.start = tmr_start;
    assign tif.abort = tmr_abort;
    assign tif.delay_code = uv_act_reg[ufc_pkg::DELAY_MSB:ufc_pkg::DELAY_LSB];

    ufc_retry_timer #(
        .STEP_CYC(STEP_WAIT_CYC),
        .LONG_CYC(LONG_WAIT_CYC)
    ) u_retry_timer (
        .clk(core_clk),
        .rst_n(rst_n),
        .tif(tif.tmr)
    );

    // State, flags, enable and alert
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ufc_pkg::ST_OFF;
            uv_flag_reg <= 1'b0;
            oc_flag_reg <= 1'b0;
            alert_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            uv_flag_reg <= uv_flag_next;
            oc_flag_reg <= oc_flag_next;
            // alert low while any flag stands
            alert_reg <= ~(uv_flag_next | oc_flag_next);
            oe_reg <= (state_next == ufc_pkg::ST_RUN);
        end
    end

    // Outputs straight from flops
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign rsp_error = rsp_error_reg;
    assign output_enable = oe_reg;
    assign uv_fault_status = uv_flag_reg;
    assign oc_fault_status = oc_flag_reg;
    assign alert_output_n = alert_reg;

    // Checks
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_UV_THR_RANGE: assert property (
        $rose(rst_n) |-> (uv_thr_reg == ufc_pkg::UV_THR_RST) ##1 (uv_thr_reg <= ufc_pkg::UV_THR_MAX))
        else $error("Undervoltage threshold reset or range wrong");

    AST_UV_MASKED: assert property (
        (!uv_arm && !uv_flag_reg) |=> !uv_flag_reg)
        else $error("Undervoltage flagged while masked");

    AST_PAGE_ZERO: assert property (
        (cmd_valid && !cmd_write && sel_oc_thr) |=> (rsp_valid && !rsp_error && rsp_rdata == $past(oc_thr_reg)))
        else $error("Read not served from page zero");

    AST_ACT_RESET: assert property (
        $rose(rst_n) |-> (uv_act_reg == ufc_pkg::UV_ACT_RST))
        else $error("Response byte reset value wrong");

    AST_ACT_LEGAL: assert property (
        (cmd_valid && cmd_write && sel_uv_act && cmd_wdata[ufc_pkg::ACT_MSB:ufc_pkg::ACT_LSB] == 2'h1)
        |=> (rsp_error && uv_act_reg == $past(uv_act_reg)))
        else $error("Unsupported action accepted");

    AST_UV_ALERT: assert property (
        uv_trip |=> (!alert_output_n && uv_fault_status))
        else $error("Undervoltage did not raise alert and status");

    AST_LATCH_OFF: assert property (
        (uv_disable && enable_req && !other_fault_off && retry_field == ufc_pkg::RETRY_NONE)
        |=> (!output_enable && state_reg == ufc_pkg::ST_LATCHED) ##1 !output_enable)
        else $error("No-retry fault did not latch the output off");

    AST_RETRY_RESUME: assert property (
        (state_reg == ufc_pkg::ST_RETRY_WAIT && tif.done && enable_req && !other_fault_off)
        |=> (output_enable && state_reg == ufc_pkg::ST_RUN))
        else $error("Retry did not restart the output");

    AST_RETRY_STOP: assert property (
        (state_reg == ufc_pkg::ST_RETRY_WAIT && !enable_req) |=> (state_reg == ufc_pkg::ST_OFF && !tif.busy))
        else $error("Retries continued after turn off");

    AST_OC_THR_RANGE: assert property (
        (cmd_valid && cmd_write && sel_oc_thr && cmd_wdata > ufc_pkg::OC_THR_MAX) |=> (oc_thr_reg == $past(oc_thr_reg)))
        else $error("Overcurrent threshold accepted out of range");

    AST_OC_TRIP: assert property (
        (meas_valid && iout_sum > oc_thr_reg) |=> (oc_fault_status && !alert_output_n))
        else $error("Overcurrent above threshold not flagged");

    COV_RETRY_CYCLE: cover property (
        (state_reg == ufc_pkg::ST_RUN) ##1 (state_reg == ufc_pkg::ST_RETRY_WAIT) ##[1:40] (state_reg == ufc_pkg::ST_RUN));
    COV_LATCHED: cover property (state_reg == ufc_pkg::ST_LATCHED);
    COV_CONTINUE: cover property (uv_trip && act_field == ufc_pkg::ACT_CONTINUE);
    COV_REFUSED: cover property (rsp_valid && rsp_error);
endmodule

// ---- ufc_pkg.sv ----
// Constants, field layout and state type of the output fault configuration block
package ufc_pkg;
    // Command codes; every access lands on page zero
    localparam logic [7:0] CMD_UV_THR = 8'h44;
    localparam logic [7:0] CMD_UV_ACT = 8'h45;
    localparam logic [7:0] CMD_OC_THR = 8'h46;

    // Reset values
    localparam logic [15:0] UV_THR_RST = 16'h0921;
    localparam logic [7:0] UV_ACT_RST = 8'h84;
    localparam logic [15:0] OC_THR_RST = 16'h01F4;

    // Highest accepted threshold values (3050 mV, 3276.7 A)
    localparam logic [15:0] UV_THR_MAX = 16'h0BEA;
    localparam logic [15:0] OC_THR_MAX = 16'h7FFF;

    // Field positions of the response byte
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;

    // Field encodings
    localparam logic [1:0] ACT_CONTINUE = 2'h0;
    localparam logic [1:0] ACT_DISABLE = 2'h2;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam logic [2:0] DELAY_LONG = 3'h7;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Retry timing at the core clock rate
    localparam int CORE_CLK_MHZ = 100;
    localparam int RETRY_STEP_MS = 25;
    localparam int RETRY_LONG_MS = 175;
    localparam int RETRY_STEP_CYC = RETRY_STEP_MS * 1000 * CORE_CLK_MHZ;
    localparam int RETRY_LONG_CYC = RETRY_LONG_MS * 1000 * CORE_CLK_MHZ;

    // Output control states
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_RETRY_WAIT, ST_LATCHED} ufc_state_e;
endpackage

// ---- ufc_timer_if.sv ----
// Handshake between the fault controller and its retry delay timer
`timescale 1ns/1ps
interface ufc_timer_if;
    logic start;
    logic abort;
    logic [2:0] delay_code;
    logic done;
    logic busy;
    modport ctl (output start, output abort, output delay_code, input done, input busy);
    modport tmr (input start, input abort, input delay_code, output done, output busy);
endinterface

// ---- ufc_retry_timer.sv ----
// Retry delay timer: waits the time that the delay code selects, then pulses done
`timescale 1ns/1ps
module ufc_retry_timer #(
    parameter logic [31:0] STEP_CYC = 32'(ufc_pkg::RETRY_STEP_CYC),
    parameter logic [31:0] LONG_CYC = 32'(ufc_pkg::RETRY_LONG_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    ufc_timer_if.tmr tif
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;
    logic [31:0] load_val;
    logic [31:0] elapsed_reg;
    logic [31:0] expect_reg;

    assign load_val = (tif.delay_code == ufc_pkg::DELAY_LONG) ? LONG_CYC : 32'(STEP_CYC * 32'(tif.delay_code));
    assign tif.done = done_reg;
    assign tif.busy = busy_reg;

    // Load, count down, pulse done on expiry
    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (tif.abort) begin
            busy_next = 1'b0;
            cnt_next = 32'h0;
        end else if (tif.start) begin
            busy_next = (load_val != 32'h0);
            cnt_next = load_val;
            done_next = (load_val == 32'h0);
        end else if (busy_reg) begin
            if (cnt_reg <= 32'h1) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                cnt_next = 32'h0;
            end else begin
                cnt_next = cnt_reg - 32'h1;
            end
        end
    end

    // Timer state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    // Helper: edges since the last start and the wait that start asked for
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed_reg <= 32'h0;
            expect_reg <= 32'h0;
        end else if (tif.start) begin
            elapsed_reg <= 32'h0;
            expect_reg <= load_val;
        end else begin
            elapsed_reg <= elapsed_reg + 32'h1;
        end
    end

    AST_RETRY_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
        done_reg |-> (elapsed_reg == expect_reg))
        else $error("Retry wait length differs from the delay code");
endmodule

// ---- ufc_host_model.sv ----
// Host controller model that drives the command port and collects each answer
`timescale 1ns/1ps
module ufc_host_model (
    input wire logic core_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_page,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic rsp_error
);
    logic last_valid;
    logic last_error;
    logic [15:0] last_rdata;
    // Quiet lines at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_page = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // One command after gap idle cycles; lines invert once it is taken
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page,
                        input logic [15:0] data, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_page <= page;
        cmd_wdata <= data;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_write <= ~wr;
        cmd_code <= ~code;
        cmd_page <= ~page;
        cmd_wdata <= ~data;
        @(negedge core_clk);
        last_valid = rsp_valid;
        last_error = rsp_error;
        last_rdata = rsp_rdata;
    endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench of the fault configuration block against a behavioural model
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid, cmd_write, rsp_valid, rsp_error;
    logic [7:0] cmd_code, cmd_page;
    logic [15:0] cmd_wdata, rsp_rdata;
    logic [15:0] vout_mv = 16'h0FFF;
    logic [15:0] iout_sum = 16'h0000;
    logic meas_valid = 1'b0;
    logic output_ramping = 1'b0;
    logic op_on = 1'b0;
    logic other_fault_off = 1'b0;
    logic fault_clear = 1'b0;
    logic ctrl_pin = 1'b0;
    logic bias_ok = 1'b0;
    logic output_enable, uv_fault_status, oc_fault_status, alert_output_n;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 23;
    int m_reg[3] = '{'h0921, 'h84, 'h01F4};
    int d_tab[5] = '{0, 1, 3, 6, 7};

    ufc_fault_cfg #(.STEP_WAIT_CYC(32'h4), .LONG_WAIT_CYC(32'h1C)) u_ufc_fault_cfg (
        .core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .vout_mv(vout_mv), .iout_sum(iout_sum),
        .meas_valid(meas_valid), .output_ramping(output_ramping), .op_on(op_on),
        .other_fault_off(other_fault_off), .fault_clear(fault_clear), .ctrl_pin(ctrl_pin),
        .bias_ok(bias_ok), .output_enable(output_enable), .uv_fault_status(uv_fault_status),
        .oc_fault_status(oc_fault_status), .alert_output_n(alert_output_n));
    ufc_host_model u_ufc_host_model (
        .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_error(rsp_error));

    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("MISMATCH t=%0t run did not finish", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    // Acceptance of a write value by the model
    function automatic bit legal(int idx, int d);
        if (idx == 0) return d <= 'h0BEA;
        if (idx == 2) return d <= 'h7FFF;
        return (d >> 8) == 0 && ((d >> 6) & 1) == 0 && (((d >> 3) & 7) == 0 || ((d >> 3) & 7) == 7);
    endfunction

    // Command through the host, answer compared with the model
    task automatic cmd(input bit wr, input logic [7:0] code, input logic [15:0] data);
        int idx;
        bit ok;
        idx = int'(code) - 'h44;
        ok = idx >= 0 && idx < 3 && (!wr || legal(idx, data));
        u_ufc_host_model.xfer(wr, code, 8'($random(seed)), data, $random(seed) & 1);
        chk1(u_ufc_host_model.last_valid, 1'b1, "answer valid");
        chk1(u_ufc_host_model.last_error, !ok, "answer error");
        chk16(u_ufc_host_model.last_rdata, (ok && !wr) ? 16'(m_reg[idx]) : 16'h0000, "read data");
        if (ok && wr) m_reg[idx] = data;
    endtask

    task automatic meas(input logic [15:0] v, input logic [15:0] i);
        @(posedge core_clk);
        vout_mv <= v;
        iout_sum <= i;
        meas_valid <= 1'b1;
        @(posedge core_clk);
        meas_valid <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic wait_oe(input logic exp, input int lim);
        int n;
        n = 0;
        while (output_enable !== exp && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        chk1(output_enable, exp, "output enable");
    endtask

    task automatic flags(input logic uv, input logic oc);
        chk1(uv_fault_status, uv, "uv flag");
        chk1(oc_fault_status, oc, "oc flag");
        chk1(alert_output_n, !(uv || oc), "alert");
    endtask

    // Main sequence
    initial begin
        int v;
        int n;
        int d;
        repeat (6) @(posedge core_clk);
        flags(1'b0, 1'b0);
        resetn <= 1'b1;
        repeat (5) @(posedge core_clk);
        for (int c = 'h43; c <= 'h47; c++) cmd(0, 8'(c), 16'h0000);
        foreach (d_tab[k]) cmd(1, 8'h44, 16'h0BEA + 16'(k));
        cmd(1, 8'h46, 16'h8000);
        cmd(1, 8'h46, 16'h7FFF);
        cmd(1, 8'h45, 16'h0100);
        for (int b = 0; b < 256; b++) begin
            cmd(1, 8'h45, 16'(b));
            cmd(0, 8'h45, 16'h0000);
        end
        $display("test registers done");
        cmd(1, 8'h45, 16'h0000);
        @(posedge core_clk);
        {op_on, ctrl_pin, bias_ok} <= 3'h7;
        wait_oe(1'b1, 12);
        for (int k = 0; k < 12; k++) begin
            cmd(1, 8'h44, 16'($random(seed)) % 16'h0BEB);
            cmd(1, 8'h46, 16'($random(seed)) & 16'h7FFF);
            v = (k == 0) ? m_reg[0] : ($random(seed) & 'h0FFF);
            n = (k == 1) ? m_reg[2] : ($random(seed) & 'h7FFF);
            meas(16'(v), 16'(n));
            flags(v < m_reg[0], n > m_reg[2]);
            chk1(output_enable, 1'b1, "continue keeps output");
            @(posedge core_clk);
            fault_clear <= 1'b1;
            @(posedge core_clk);
            fault_clear <= 1'b0;
            @(negedge core_clk);
            flags(1'b0, 1'b0);
        end
        cmd(1, 8'h44, 16'h0921);
        cmd(1, 8'h46, 16'h7FFF);
        $display("test thresholds done");
        output_ramping <= 1'b1;
        meas(16'h0000, 16'h0000);
        flags(1'b0, 1'b0);
        output_ramping <= 1'b0;
        op_on <= 1'b0;
        wait_oe(1'b0, 6);
        meas(16'h0000, 16'h0000);
        flags(1'b0, 1'b0);
        cmd(1, 8'h45, 16'h0080);
        op_on <= 1'b1;
        wait_oe(1'b1, 6);
        meas(16'h0000, 16'h0000);
        chk1(output_enable, 1'b0, "latched off");
        vout_mv <= 16'h0FFF;
        repeat (40) @(negedge core_clk);
        chk1(output_enable, 1'b0, "stays latched");
        op_on <= 1'b0;
        repeat (3) @(posedge core_clk);
        op_on <= 1'b1;
        wait_oe(1'b1, 6);
        other_fault_off <= 1'b1;
        @(posedge core_clk);
        other_fault_off <= 1'b0;
        repeat (40) @(negedge core_clk);
        chk1(output_enable, 1'b0, "other fault stops");
        op_on <= 1'b0;
        repeat (3) @(posedge core_clk);
        op_on <= 1'b1;
        wait_oe(1'b1, 6);
        $display("test latch done");
        foreach (d_tab[k]) begin
            d = d_tab[k];
            cmd(1, 8'h45, 16'h00B8 | 16'(d));
            meas(16'h0000, 16'h0000);
            vout_mv <= 16'h0FFF;
            chk1(output_enable, 1'b0, "retry off");
            n = 0;
            while (output_enable !== 1'b1 && n < 100) begin
                @(negedge core_clk);
                n++;
            end
            chk16(16'(n), 16'((d == 0) ? 1 : (d == 7) ? 29 : d * 4 + 1), "retry wait");
        end
        meas(16'h0000, 16'h0000);
        repeat (5) @(posedge core_clk);
        ctrl_pin <= 1'b0;
        repeat (60) @(negedge core_clk);
        chk1(output_enable, 1'b0, "pin stops retry");
        ctrl_pin <= 1'b1;
        wait_oe(1'b1, 12);
        // Bias loss during the long retry wait must also end the retries
        meas(16'h0000, 16'h0000);
        bias_ok <= 1'b0;
        repeat (60) @(negedge core_clk);
        chk1(output_enable, 1'b0, "bias loss stops retry");
        bias_ok <= 1'b1;
        wait_oe(1'b1, 12);
        $display("test retry done");
        final_report();
    end
endmodule
